// >>> bmu_defines.vh
// Shared constants for the binary and decimal multiply unit.
`ifndef BMU_DEFINES_VH
`define BMU_DEFINES_VH
`define BMU_OP_DUMUL 2'h0
`define BMU_OP_DECMUL 2'h1
`define BMU_OP_DDECMUL 2'h2
`define BMU_OP_NONE 2'h3
`define BMU_WORD_W 16
`define BMU_DIGIT_MAX 4'h9
`define BMU_NEG_BIT 63
`endif

// >>> bmu_bcd_mul.v
// Sequential decimal multiplier working digit by digit with shift-and-add.
`timescale 1ns/10ps
`include "bmu_defines.vh"
module bmu_bcd_mul #(
  parameter DIGITS = 8
) (
  input wire i_clk_sys,                      // System clock.
  input wire i_rst,                          // Synchronous reset, active high.
  input wire i_start,                        // One-cycle start pulse.
  input wire [4*DIGITS-1:0] i_mcand,         // Multiplicand digits.
  input wire [4*DIGITS-1:0] i_mplier,        // Multiplier digits.
  output reg o_done,                         // One-cycle completion pulse.
  output reg [8*DIGITS-1:0] o_product        // Decimal product.
);
  localparam PW = 8 * DIGITS;
  localparam [7:0] LAST_DIG = DIGITS - 1;
  reg [PW-1:0] acc_q;
  reg [4*DIGITS-1:0] mpl_q;
  reg [3:0] rep_q;
  reg [7:0] dig_q;
  reg busy_q;
  wire [PW-1:0] mcand_ext = {{(PW-4*DIGITS){1'b0}}, i_mcand};
  reg [PW-1:0] mcand_q;

  // Decimal addition of two packed digit strings, carry propagating upward.
  function [PW-1:0] dec_add;
    input [PW-1:0] a;
    input [PW-1:0] b;
    integer k;
    reg [4:0] s;
    reg c;
    begin
      c = 1'b0;
      dec_add = {PW{1'b0}};
      for (k = 0; k < 2 * DIGITS; k = k + 1) begin
        s = {1'b0, a[4*k +: 4]} + {1'b0, b[4*k +: 4]} + {4'h0, c};
        if (s > 5'd9) begin
          s = s + 5'd6;
          c = 1'b1;
        end else begin
          c = 1'b0;
        end
        dec_add[4*k +: 4] = s[3:0];
      end
    end
  endfunction

  // Multiplier digits are consumed from the top; each digit adds the
  // multiplicand that many times after a decimal shift. Slow but small.
  always @(posedge i_clk_sys) begin
    o_done <= 1'b0;
    if (i_rst) begin
      acc_q <= {PW{1'b0}};
      mpl_q <= {(4*DIGITS){1'b0}};
      mcand_q <= {PW{1'b0}};
      rep_q <= 4'h0;
      dig_q <= 8'h00;
      busy_q <= 1'b0;
      o_product <= {PW{1'b0}};
    end else if (i_start) begin
      acc_q <= {PW{1'b0}};
      mpl_q <= i_mplier;
      mcand_q <= mcand_ext;
      rep_q <= i_mplier[4*DIGITS-1 -: 4];
      dig_q <= 8'h00;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (rep_q != 4'h0) begin
        acc_q <= dec_add(acc_q, mcand_q);
        rep_q <= rep_q - 4'h1;
      end else if (dig_q == LAST_DIG) begin
        busy_q <= 1'b0;
        o_done <= 1'b1;
        o_product <= acc_q;
      end else begin
        acc_q <= {acc_q[PW-5:0], 4'h0};
        mpl_q <= {mpl_q[4*DIGITS-5:0], 4'h0};
        rep_q <= mpl_q[4*DIGITS-5 -: 4];
        dig_q <= dig_q + 8'h01;
      end
    end
  end
endmodule

// >>> bmu_multiply_unit.v
// Multiply unit: double binary, single decimal and double decimal products.
// Notes on behaviour
// (RQ1) Double binary: 32x32 unsigned into four words.
// (RQ2) Double binary always clears the error flag.
// (RQ3) Negative flag follows product bit 63; decimal operations leave it unchanged.
// (RQ4) Equals flag set when whole product zero.
// (RQ5) Lowest product word at base, highest base+3.
// (RQ6) Single decimal: four digits, two-word product.
// (RQ7) Single decimal: invalid digit raises error flag.
// (RQ8) Double decimal: eight digits, four-word product.
// (RQ9) Double decimal: any invalid word raises error.
// (RQ10) Trigger each cycle or on rising edge.
// (RQ11) Invalid input leaves results and equals untouched.
`timescale 1ns/10ps
`include "bmu_defines.vh"
module bmu_multiply_unit #(
  parameter WORD_W = `BMU_WORD_W
) (
  input wire i_clk_sys,                 // System clock, 40 MHz.
  input wire i_rst,                     // Synchronous reset, active high.
  input wire i_cond,                    // Execution condition from sequencing.
  input wire i_edge_mode,               // 1: run once per rising edge of i_cond.
  input wire [1:0] i_op,                // Operation select.
  input wire [WORD_W-1:0] i_mcand_lo,   // multiplicand_word.
  input wire [WORD_W-1:0] i_mcand_hi,   // multiplicand_word plus one.
  input wire [WORD_W-1:0] i_mplier_lo,  // multiplier_word.
  input wire [WORD_W-1:0] i_mplier_hi,  // multiplier_word plus one.
  output wire o_busy,                   // Operation in progress.
  output reg o_wr_valid,                // Result write pulse.
  output reg [3:0] o_wr_mask,           // Result words written, bit n is base+n.
  output reg [WORD_W-1:0] o_res0,       // Result word at base.
  output reg [WORD_W-1:0] o_res1,       // Result word at base plus one.
  output reg [WORD_W-1:0] o_res2,       // Result word at base plus two.
  output reg [WORD_W-1:0] o_res3,       // Result word at base plus three.
  output reg o_error_flag,              // Error flag.
  output reg o_equals_flag,             // Equals flag.
  output reg o_negative_flag            // Negative flag.
);
  // Sequencer states in plain binary.
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RUN = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;
  reg [1:0] st_q;
  reg [1:0] op_q;
  reg cond_q;
  reg [63:0] bin_prod_q;
  reg dec_start_q;
  reg dec_short_q;
  wire dec_done;
  wire [63:0] dec_prod;
  wire fire;
  wire bad_short;
  wire bad_long;
  wire [63:0] bin_prod;

  // True when any nibble of a word is above nine.
  function word_bad;
    input [WORD_W-1:0] w;
    integer k;
    begin
      word_bad = 1'b0;
      for (k = 0; k < WORD_W / 4; k = k + 1) begin
        if (w[4*k +: 4] > `BMU_DIGIT_MAX) begin
          word_bad = 1'b1;
        end
      end
    end
  endfunction

  // True when every word of a product is zero; used by both result paths.
  function prod_zero;
    input [63:0] p;
    begin
      prod_zero = (p == 64'h0000000000000000);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // (RQ10) Trigger form select.
  // Edge form is armed only by a low-to-high change seen from idle.
  // A rising edge that arrives while busy is dropped; the caller re-arms.
  assign fire = (st_q == ST_IDLE) && i_cond && (!i_edge_mode || !cond_q) && (i_op != `BMU_OP_NONE);
  assign o_busy = (st_q != ST_IDLE);
  // (RQ1) Operands widened first so the full 64-bit product is kept.
  assign bin_prod = {32'h00000000, i_mcand_hi, i_mcand_lo} * {32'h00000000, i_mplier_hi, i_mplier_lo};
  // (RQ7) Single decimal check.
  assign bad_short = word_bad(i_mcand_lo) || word_bad(i_mplier_lo);
  // (RQ9) Double decimal check.
  assign bad_long = bad_short || word_bad(i_mcand_hi) || word_bad(i_mplier_hi);

  // Condition history for edge detection; same-domain input, no synchroniser.
  // Reset to the idle level of the condition, so a condition already high at release reads as an edge.
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      cond_q <= 1'b0;
    end else begin
      cond_q <= i_cond;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The decimal core is shared; short operands are zero-extended so the
  // upper digits of the sixteen-digit product fill with zero.
  bmu_bcd_mul #(
    .DIGITS(8)
  ) u_dec (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_start(dec_start_q),
    .i_mcand(dec_short_q ? {16'h0000, i_mcand_lo} : {i_mcand_hi, i_mcand_lo}),
    .i_mplier(dec_short_q ? {16'h0000, i_mplier_lo} : {i_mplier_hi, i_mplier_lo}),
    .o_done(dec_done),
    .o_product(dec_prod)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: binary finishes in two cycles, decimal waits for the core.
  // Operands must stay stable while o_busy is high.
  always @(posedge i_clk_sys) begin
    o_wr_valid <= 1'b0;
    dec_start_q <= 1'b0;
    if (i_rst) begin
      // Results and flags start at zero so a first read sees a clean state.
      st_q <= ST_IDLE;
      op_q <= `BMU_OP_NONE;
      bin_prod_q <= 64'h0000000000000000;
      dec_short_q <= 1'b0;
      o_wr_mask <= 4'h0;
      o_res0 <= {WORD_W{1'b0}};
      o_res1 <= {WORD_W{1'b0}};
      o_res2 <= {WORD_W{1'b0}};
      o_res3 <= {WORD_W{1'b0}};
      o_error_flag <= 1'b0;
      o_equals_flag <= 1'b0;
      o_negative_flag <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          // A refused run leaves the error flag up until the next operation
          // completes, so the sequencing logic can still see it afterwards.
          if (fire) begin
            op_q <= i_op;
            case (i_op)
              `BMU_OP_DUMUL: begin
                // (RQ1) 64-bit unsigned product of 32-bit operands.
                bin_prod_q <= bin_prod;
                st_q <= ST_DONE;
              end
              `BMU_OP_DECMUL: begin
                // (RQ11) Invalid input: error only, nothing written.
                if (bad_short) begin
                  o_error_flag <= 1'b1;
                end else begin
                  dec_short_q <= 1'b1;
                  dec_start_q <= 1'b1;
                  st_q <= ST_RUN;
                end
              end
              `BMU_OP_DDECMUL: begin
                // (RQ11) Invalid input: error only, nothing written.
                if (bad_long) begin
                  o_error_flag <= 1'b1;
                end else begin
                  dec_short_q <= 1'b0;
                  dec_start_q <= 1'b1;
                  st_q <= ST_RUN;
                end
              end
              default: begin
                // No operation selected; fire already keeps this code out.
                st_q <= ST_IDLE;
              end
            endcase
          end
        end
        ST_DONE: begin
          // The product register keeps the long multiplier path off the outputs.
          // (RQ5) Low word at base, high at base plus three.
          o_res0 <= bin_prod_q[15:0];
          o_res1 <= bin_prod_q[31:16];
          o_res2 <= bin_prod_q[47:32];
          o_res3 <= bin_prod_q[63:48];
          o_wr_mask <= 4'hf;
          o_wr_valid <= 1'b1;
          // (RQ2) No operand is an error here.
          o_error_flag <= 1'b0;
          // (RQ4) Zero product detect.
          o_equals_flag <= prod_zero(bin_prod_q);
          // (RQ3) Top bit of the fourth word.
          o_negative_flag <= bin_prod_q[`BMU_NEG_BIT];
          st_q <= ST_IDLE;
        end
        ST_RUN: begin
          // The negative flag is left alone: a decimal product has no sign.
          if (dec_done) begin
            o_wr_valid <= 1'b1;
            o_error_flag <= 1'b0;
            // (RQ4) Zero product detect.
            o_equals_flag <= prod_zero(dec_prod);
            o_res0 <= dec_prod[15:0];
            o_res1 <= dec_prod[31:16];
            // (RQ6) Two-word product for the short form.
            // The upper two result words keep what they held before.
            if (op_q == `BMU_OP_DECMUL) begin
              o_wr_mask <= 4'h3;
            end else begin
              // (RQ8) Four-word product for the long form.
              o_res2 <= dec_prod[47:32];
              o_res3 <= dec_prod[63:48];
              o_wr_mask <= 4'hf;
            end
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> bmu_multiply_unit_chk.sv
// Port checker for the multiply unit.
`timescale 1ns/10ps
module bmu_multiply_unit_chk (
  input wire i_clk_sys, // Clock.
  input wire i_rst, // Reset.
  input wire i_cond, // Condition.
  input wire i_edge_mode, // Edge trigger.
  input wire [1:0] i_op, // Operation.
  input wire [15:0] i_mcand_lo, // Operand.
  input wire [15:0] i_mcand_hi, // Operand.
  input wire [15:0] i_mplier_lo, // Operand.
  input wire [15:0] i_mplier_hi, // Operand.
  input wire o_busy, // Busy.
  input wire o_wr_valid, // Write pulse.
  input wire [3:0] o_wr_mask, // Words written.
  input wire [15:0] o_res0, // Result.
  input wire [15:0] o_res1, // Result.
  input wire [15:0] o_res2, // Result.
  input wire [15:0] o_res3, // Result.
  input wire o_error_flag, // Error.
  input wire o_equals_flag, // Equals.
  input wire o_negative_flag // Negative.
);
  reg cond_q;
  wire take;
  wire bad;
  function nd(input [15:0] w);
    nd = w[3:0] > 4'h9 || w[7:4] > 4'h9 || w[11:8] > 4'h9 || w[15:12] > 4'h9;
  endfunction
  // The old condition is kept, since an edge request needs a low-to-high step.
  always @(posedge i_clk_sys) cond_q <= i_rst ? 1'b0 : i_cond;
  assign take = !o_busy && i_cond && i_op != 2'h3 && (!i_edge_mode || !cond_q);
  assign bad = i_op != 2'h0 && (nd(i_mcand_lo) || nd(i_mplier_lo) || (i_op == 2'h2 && (nd(i_mcand_hi) ||
    nd(i_mplier_hi))));
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  pulse_one_a: assert property (o_wr_valid |=> !o_wr_valid) else $error("Write pulse too long.");
  bin_timing_a: assert property (take && i_op == 2'h0 |=> !o_wr_valid ##1 o_wr_valid)
    else $error("Binary result not on time.");
  bin_prod_a: assert property (o_wr_valid && i_op == 2'h0 |-> {o_res3, o_res2, o_res1, o_res0} ==
    {i_mcand_hi, i_mcand_lo} * {i_mplier_hi, i_mplier_lo}) else $error("Binary product wrong.");
  neg_bit_a: assert property (o_wr_valid && i_op == 2'h0 |-> o_negative_flag == o_res3[15])
    else $error("Negative flag wrong.");
  eq_zero_a: assert property (o_wr_valid |-> o_equals_flag == ({o_wr_mask[3] ? o_res3 : 16'h0,
    o_wr_mask[2] ? o_res2 : 16'h0, o_res1, o_res0} == 64'h0)) else $error("Equals flag wrong.");
  word_mask_a: assert property (o_wr_valid |-> o_wr_mask == (i_op == 2'h1 ? 4'h3 : 4'hf))
    else $error("Write mask wrong.");
  err_clear_a: assert property (o_wr_valid |-> !o_error_flag) else $error("Error flag left set.");
  bad_digit_a: assert property (take && bad |=> o_error_flag && !o_wr_valid)
    else $error("Invalid digit not flagged.");
  keep_res_a: assert property (take && bad |=> $stable(o_res0) && $stable(o_res1) && $stable(o_equals_flag))
    else $error("Result changed on invalid input.");
  edge_once_a: assert property (i_edge_mode && cond_q && i_cond && !o_busy |=> !o_busy)
    else $error("Edge mode retriggered.");
  cover property (o_wr_valid && o_wr_mask == 4'h3);
  cover property (o_wr_valid && o_negative_flag);
  cover property (take && bad);
endmodule
bind bmu_multiply_unit bmu_multiply_unit_chk u_chk (
  .i_clk_sys(i_clk_sys),
  .i_rst(i_rst),
  .i_cond(i_cond),
  .i_edge_mode(i_edge_mode),
  .i_op(i_op),
  .i_mcand_lo(i_mcand_lo),
  .i_mcand_hi(i_mcand_hi),
  .i_mplier_lo(i_mplier_lo),
  .i_mplier_hi(i_mplier_hi),
  .o_busy(o_busy),
  .o_wr_valid(o_wr_valid),
  .o_wr_mask(o_wr_mask),
  .o_res0(o_res0),
  .o_res1(o_res1),
  .o_res2(o_res2),
  .o_res3(o_res3),
  .o_error_flag(o_error_flag),
  .o_equals_flag(o_equals_flag),
  .o_negative_flag(o_negative_flag)
);

// >>> bmu_multiply_unit_tb.sv
// Self-checking bench for the multiply unit with a reference model.
`timescale 1ns/10ps
module bmu_multiply_unit_tb;
  reg i_clk_sys = 1'b0;
  reg i_rst = 1'b1;
  reg i_cond = 1'b0;
  reg i_edge_mode = 1'b0;
  reg [1:0] i_op = 2'h3;
  reg [15:0] i_mcand_lo = 16'h0, i_mcand_hi = 16'h0, i_mplier_lo = 16'h0, i_mplier_hi = 16'h0;
  wire o_busy, o_wr_valid, o_error_flag, o_equals_flag, o_negative_flag;
  wire [3:0] o_wr_mask;
  wire [15:0] o_res0, o_res1, o_res2, o_res3;
  integer failures = 0, cmp_count = 0, cyc = 0, i;
  reg [31:0] seed = 32'haab1;
  reg [63:0] last = 64'h0;
  reg last_eq = 1'b0;
  reg [1:0] rop;
  bmu_multiply_unit dut (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_cond(i_cond),
    .i_edge_mode(i_edge_mode),
    .i_op(i_op),
    .i_mcand_lo(i_mcand_lo),
    .i_mcand_hi(i_mcand_hi),
    .i_mplier_lo(i_mplier_lo),
    .i_mplier_hi(i_mplier_hi),
    .o_busy(o_busy),
    .o_wr_valid(o_wr_valid),
    .o_wr_mask(o_wr_mask),
    .o_res0(o_res0),
    .o_res1(o_res1),
    .o_res2(o_res2),
    .o_res3(o_res3),
    .o_error_flag(o_error_flag),
    .o_equals_flag(o_equals_flag),
    .o_negative_flag(o_negative_flag)
  );
  // Free-running clock; the cycle ceiling stops a hung run.
  always #12.5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input [63:0] seen, input [63:0] exp, input string nm);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("ERROR %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Every output must read zero on the first edge after reset is released.
  task chk_reset;
    @(posedge i_clk_sys);
    #1;
    chk({o_busy, o_wr_valid, o_wr_mask, o_error_flag, o_equals_flag, o_negative_flag}, 0, "reset flags");
    chk({o_res3, o_res2, o_res1, o_res0}, 0, "reset words");
  endtask
  function [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction
  function nd(input [15:0] w);
    nd = w[3:0] > 4'h9 || w[7:4] > 4'h9 || w[11:8] > 4'h9 || w[15:12] > 4'h9;
  endfunction
  function longint b2n(input [63:0] b);
    b2n = 0;
    for (int k = 15; k >= 0; k--) b2n = b2n * 10 + b[4*k+:4];
  endfunction
  function [63:0] n2b(input longint n);
    for (int k = 0; k < 16; k++) begin
      n2b[4*k+:4] = 4'(n % 10);
      n = n / 10;
    end
  endfunction
  // Random operands stay valid: full binary or in-range decimal digits.
  function [31:0] opnd(input [1:0] op);
    seed = xs(seed);
    opnd = op == 2'h0 ? seed : 32'(n2b(seed % (op == 2'h1 ? 10000 : 100000000)));
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // One request, checked against the model, then a window counting repeats.
  task run(input [1:0] op, input md, input [31:0] a, input [31:0] b);
    reg bad;
    reg [63:0] p;
    integer k, n;
    bad = op != 2'h0 && (nd(a[15:0]) || nd(b[15:0]) || (op == 2'h2 && (nd(a[31:16]) || nd(b[31:16]))));
    p = op == 2'h0 ? {32'h0, a} * {32'h0, b} : n2b(op == 2'h1 ? b2n(a[15:0]) * b2n(b[15:0]) : b2n(a) * b2n(b));
    md = md | bad;
    @(posedge i_clk_sys);
    i_op <= op;
    i_edge_mode <= md;
    {i_mcand_hi, i_mcand_lo} <= a;
    {i_mplier_hi, i_mplier_lo} <= b;
    i_cond <= 1'b1;
    if (bad || op == 2'h3) begin
      repeat (2) @(posedge i_clk_sys);
      #1;
      if (bad) chk(o_error_flag, 1, "error");
      if (bad) chk({o_res1, o_res0, o_equals_flag}, {last[31:0], last_eq}, "kept");
    end else begin
      k = 0;
      while (o_wr_valid !== 1'b1 && k < 200) begin
        @(posedge i_clk_sys);
        #1;
        k = k + 1;
      end
      chk(o_wr_valid, 1, "done");
      last = p;
      last_eq = p == 64'h0;
      chk(op == 2'h1 ? {o_res1, o_res0} : {o_res3, o_res2, o_res1, o_res0}, p, "product");
      chk({o_error_flag, o_equals_flag, o_wr_mask}, {1'b0, last_eq, op == 2'h1 ? 4'h3 : 4'hf}, "flags");
      if (op == 2'h0) chk(o_negative_flag, p[63], "negative");
    end
    @(posedge i_clk_sys);
    i_cond <= 1'b0;
    n = 0;
    repeat (120) begin
      @(posedge i_clk_sys);
      #1;
      n = n + o_wr_valid;
    end
    chk(n, !bad && op != 2'h3 && !md, "repeats");
    chk(o_busy, 0, "idle");
  endtask
  // Reset, directed corner cases, then random operations in both modes.
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    chk_reset;
    run(2'h0, 0, 32'h0, 32'h1234abcd);
    run(2'h0, 1, 32'hffffffff, 32'hffffffff);
    run(2'h1, 0, 32'h9999, 32'h9999);
    run(2'h1, 1, 32'h0, 32'h1234);
    run(2'h2, 0, 32'h99999999, 32'h99999999);
    run(2'h1, 1, 32'h00a0, 32'h1);
    run(2'h2, 0, 32'h1, 32'hf0000001);
    run(2'h2, 1, 32'h0, 32'h0);
    run(2'h3, 0, 32'h5, 32'h5);
    // A reset in mid-run abandons a long decimal product and clears all state.
    @(posedge i_clk_sys);
    i_op <= 2'h2;
    i_edge_mode <= 1'b0;
    {i_mcand_hi, i_mcand_lo} <= 32'h99999999;
    {i_mplier_hi, i_mplier_lo} <= 32'h99999999;
    i_cond <= 1'b1;
    repeat (20) @(posedge i_clk_sys);
    #1;
    chk(o_busy, 1, "busy");
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    i_cond <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    last = 64'h0;
    last_eq = 1'b0;
    chk_reset;
    for (i = 0; i < 16; i = i + 1) begin
      seed = xs(seed);
      rop = 2'(seed % 3);
      run(rop, seed[8], opnd(rop), opnd(rop));
    end
    end_sim;
  end
endmodule
